// [hdl/stp_regs.svh]
// Register offsets, field positions, reset values and timing constants of the serial control block
`ifndef STP_REGS_SVH
`define STP_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define STP_ADDR_WDOG 5'h00
`define STP_ADDR_STEP 5'h01
`define STP_ADDR_DRIVE 5'h02
`define STP_ADDR_POWER 5'h03
`define STP_ADDR_STAT_BASE 5'h04
`define STP_NUM_CTRL 3'h4

// ****************************************************************
// Reset values and writable bits
// ****************************************************************
`define STP_CTRL_RESET 8'h00
`define STP_WMASK_WDOG 8'hf8
`define STP_WMASK_STEP 8'hff
`define STP_WMASK_DRIVE 8'hcf
`define STP_WMASK_POWER 8'hf0

// ****************************************************************
// Field positions
// ****************************************************************
`define STP_CMD_RW_BIT 7
`define STP_WDOG_ARM_BIT 7
`define STP_WDOG_SEL_LSB 3
`define STP_SLEEP_BIT 6
`define STP_WARM_BOOT_BIT 6

// ****************************************************************
// Timing
// ****************************************************************
`define STP_MCLK_HZ 25000000
`define STP_WDOG_UNIT_MS 32
`define STP_WDOG_PULSE_CYCLES 16'h0010

`endif

// [hdl/stp_pkg.sv]
// Types shared by the serial control block
package stp_pkg;

  // ****************************************************************
  // Control fields decoded for the motor logic
  // ****************************************************************
  typedef struct packed {
    logic wdog_arm;
    logic [3:0] wdog_interval_sel;
    logic [2:0] step_mode_sel;
    logic [4:0] peak_current_sel;
    logic rotation_dir_sel;
    logic step_edge_sel;
    logic pwm_freq_sel;
    logic pwm_jitter_en;
    logic [1:0] slope_sel;
    logic motor_enable;
    logic sleep_req;
    logic bemf_gain_sel;
    logic bemf_transparent;
  } stp_ctrl_out_t;

  // Four status registers of seven flags each
  typedef logic [3:0][6:0] stp_status_t;

  // ****************************************************************
  // System clock state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] cs_sync;
    logic cs_prev;
    logic [1:0] hr_sync;
    logic [3:0][7:0] ctrl;
    stp_status_t stat;
    stp_status_t pend;
    logic fault_n;
    logic por_n;
    logic [31:0] ucnt;
    logic [4:0] tcnt;
    logic [15:0] pcnt;
  } stp_sys_t;

  // ****************************************************************
  // Link state sampled on rising serial clock
  // ****************************************************************
  typedef struct packed {
    logic [6:0] shin;
    logic [4:0] ptr;
    logic in_wr;
    logic wr_valid;
    logic bad;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] rd_mask;
  } stp_rx_t;

  // Link frame position, cleared while deselected
  typedef struct packed {
    logic act;
    logic [2:0] bitcnt;
  } stp_pos_t;

endpackage

// [hdl/stp_spi_slave.sv]
// Serial slave register block with watchdog, hard reset and sleep control
`timescale 1ns/1ps
`default_nettype none
`include "stp_regs.svh"

module stp_spi_slave
  import stp_pkg::*;
#(
  parameter int WDOG_UNIT_CYCLES = `STP_WDOG_UNIT_MS * (`STP_MCLK_HZ / 1000),
  parameter int WDOG_MIN_CYCLES = 1,
  parameter logic [15:0] WDOG_PULSE_CYCLES = `STP_WDOG_PULSE_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic spi_clk,
  input wire logic chip_sel_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic hard_reset_in,
  input wire stp_status_t status_evt,
  output stp_ctrl_out_t ctrl_out,
  output logic fault_out_n,
  output logic por_wdog_out_n,
  output logic drivers_hiz,
  output logic osc_run
);

  // ****************************************************************
  // State
  // ****************************************************************
  stp_sys_t sys;
  stp_sys_t next_sys;
  stp_rx_t rx;
  stp_rx_t next_rx;
  stp_pos_t pos;
  stp_pos_t next_pos;
  logic [7:0] out_sr;
  logic [7:0] next_out_sr;
  logic link_rst;

  // Readback value of any address; unmapped addresses read zero
  function automatic logic [7:0] reg_rd(input logic [4:0] a, input stp_sys_t s);
    logic [6:0] st;
    st = s.stat[a[1:0]];
    if (a < 5'(`STP_NUM_CTRL)) begin
      reg_rd = s.ctrl[a[1:0]];
    end else if (a[4:2] == 3'(`STP_ADDR_STAT_BASE >> 2)) begin
      reg_rd = {^st, st};
    end else begin
      reg_rd = 8'h00;
    end
  endfunction

  function automatic logic [7:0] wmask(input logic [1:0] a);
    case (a)
      2'h0: wmask = `STP_WMASK_WDOG;
      2'h1: wmask = `STP_WMASK_STEP;
      2'h2: wmask = `STP_WMASK_DRIVE;
      default: wmask = `STP_WMASK_POWER;
    endcase
  endfunction

  // ****************************************************************
  // Link: frame position, cleared whenever deselected
  // ****************************************************************
  assign link_rst = reset | chip_sel_n;

  always_comb begin
    next_pos.act = 1'b1;
    next_pos.bitcnt = pos.bitcnt + 3'h1;
  end

  always_ff @(posedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      pos <= '0;
    end else begin
      pos <= next_pos;
    end
  end

  // ****************************************************************
  // Link: command decode on rising edge
  // ****************************************************************
  always_comb begin
    logic [7:0] b;
    b = {rx.shin, serial_in};
    next_rx = rx;
    if (!pos.act) begin
      next_rx.in_wr = 1'b0;
      next_rx.wr_valid = 1'b0;
      next_rx.bad = 1'b0;
      next_rx.rd_mask = 4'h0;
    end
    next_rx.shin = {rx.shin[5:0], serial_in};
    if (pos.bitcnt == 3'h7) begin
      if (next_rx.in_wr) begin
        next_rx.wr_data = b;
        next_rx.wr_valid = 1'b1;
        next_rx.in_wr = 1'b0;
      end else if (next_rx.wr_valid) begin
        next_rx.bad = 1'b1;
      end else begin
        next_rx.ptr = b[4:0];
        if (b[`STP_CMD_RW_BIT]) begin
          next_rx.in_wr = 1'b1;
          next_rx.wr_addr = b[4:0];
        end else if (b[4:2] == 3'(`STP_ADDR_STAT_BASE >> 2)) begin
          next_rx.rd_mask[b[1:0]] = 1'b1;
        end
      end
    end else if (next_rx.wr_valid) begin
      next_rx.bad = 1'b1;
    end
  end

  always_ff @(posedge spi_clk or posedge reset) begin
    if (reset) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // ****************************************************************
  // Link: output shift register on falling edge
  // ****************************************************************
  // Outside hard reset, registers only change while deselected, so the read is stable here
  always_comb begin
    if (pos.act && pos.bitcnt == 3'h0) begin
      next_out_sr = reg_rd(rx.ptr, sys);
    end else begin
      next_out_sr = {out_sr[6:0], 1'b0};
    end
  end

  always_ff @(negedge spi_clk or posedge reset) begin
    if (reset) begin
      out_sr <= 8'h00;
    end else begin
      out_sr <= next_out_sr;
    end
  end

  assign serial_out = out_sr[7];
  assign serial_out_oe = ~chip_sel_n;

  // ****************************************************************
  // System clock: commit, status, watchdog, hard reset
  // ****************************************************************
  always_comb begin
    logic cs_hi;
    logic commit;
    logic sleep;
    logic armed;
    logic kick;
    logic fire;
    logic [4:0] limit;
    cs_hi = sys.cs_sync[1];
    commit = cs_hi & ~sys.cs_prev;
    sleep = sys.ctrl[3][`STP_SLEEP_BIT];
    armed = sys.ctrl[0][`STP_WDOG_ARM_BIT];
    kick = 1'b0;
    fire = 1'b0;
    limit = {1'b0, sys.ctrl[0][6:3]} + 5'h01;
    next_sys = sys;
    next_sys.cs_sync = {sys.cs_sync[0], chip_sel_n};
    next_sys.hr_sync = {sys.hr_sync[0], hard_reset_in};
    next_sys.cs_prev = cs_hi;
    next_sys.pend = sys.pend | status_evt;
    // Frame results are held still by the stopped serial clock
    if (commit && rx.wr_valid && !rx.bad && rx.wr_addr < 5'(`STP_NUM_CTRL)) begin
      next_sys.ctrl[rx.wr_addr[1:0]] = rx.wr_data & wmask(rx.wr_addr[1:0]);
      kick = (rx.wr_addr == `STP_ADDR_WDOG) && rx.wr_data[`STP_WDOG_ARM_BIT];
    end
    // Watchdog: unit counter of 32 ms, then count of units
    if (armed && !sleep) begin
      if (kick) begin
        fire = (sys.tcnt == 5'h00) && (sys.ucnt < 32'(WDOG_MIN_CYCLES));
        next_sys.ucnt = 32'h0;
        next_sys.tcnt = 5'h00;
      end else if (sys.ucnt == 32'(WDOG_UNIT_CYCLES - 1)) begin
        next_sys.ucnt = 32'h0;
        next_sys.tcnt = sys.tcnt + 5'h01;
        if (sys.tcnt + 5'h01 == limit) begin
          fire = 1'b1;
          next_sys.tcnt = 5'h00;
        end
      end else begin
        next_sys.ucnt = sys.ucnt + 32'h1;
      end
    end else if (!armed) begin
      next_sys.ucnt = 32'h0;
      next_sys.tcnt = 5'h00;
    end
    if (fire) begin
      next_sys.pcnt = WDOG_PULSE_CYCLES;
      next_sys.pend[0][`STP_WARM_BOOT_BIT] = 1'b1;
    end else if (sys.pcnt != 16'h0000) begin
      next_sys.pcnt = sys.pcnt - 16'h0001;
    end
    next_sys.por_n = (next_sys.pcnt == 16'h0000);
    // Status and fault follow only while deselected; set wins over clear
    if (cs_hi) begin
      for (int i = 0; i < 4; i++) begin
        if (commit && rx.rd_mask[i]) begin
          next_sys.stat[i] = 7'h00;
        end
        next_sys.stat[i] = next_sys.stat[i] | next_sys.pend[i];
      end
      next_sys.pend = status_evt;
      next_sys.fault_n = ~(|next_sys.stat[3:1] |
        |next_sys.stat[0][5:0]);
    end
    // Hard reset acts while held, except in sleep
    if (sys.hr_sync[1] && !sleep) begin
      next_sys.ctrl = '0;
      next_sys.stat = '0;
      next_sys.pend = '0;
      next_sys.ucnt = 32'h0;
      next_sys.tcnt = 5'h00;
      next_sys.pcnt = 16'h0000;
      next_sys.por_n = 1'b1;
      next_sys.fault_n = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sys <= '0;
      sys.cs_sync <= 2'b11;
      sys.cs_prev <= 1'b1;
      sys.fault_n <= 1'b1;
      sys.por_n <= 1'b1;
    end else begin
      sys <= next_sys;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ctrl_out.wdog_arm = sys.ctrl[0][7];
  assign ctrl_out.wdog_interval_sel = sys.ctrl[0][6:3];
  assign ctrl_out.step_mode_sel = sys.ctrl[1][7:5];
  assign ctrl_out.peak_current_sel = sys.ctrl[1][4:0];
  assign ctrl_out.rotation_dir_sel = sys.ctrl[2][7];
  assign ctrl_out.step_edge_sel = sys.ctrl[2][6];
  assign ctrl_out.pwm_freq_sel = sys.ctrl[2][3];
  assign ctrl_out.pwm_jitter_en = sys.ctrl[2][2];
  assign ctrl_out.slope_sel = sys.ctrl[2][1:0];
  assign ctrl_out.motor_enable = sys.ctrl[3][7];
  assign ctrl_out.sleep_req = sys.ctrl[3][6];
  assign ctrl_out.bemf_gain_sel = sys.ctrl[3][5];
  assign ctrl_out.bemf_transparent = sys.ctrl[3][4];
  assign fault_out_n = sys.fault_n;
  assign por_wdog_out_n = sys.por_n;
  assign drivers_hiz = sys.ctrl[3][`STP_SLEEP_BIT];
  assign osc_run = ~sys.ctrl[3][`STP_SLEEP_BIT] | ~sys.cs_sync[1];

endmodule
`default_nettype wire

// [test/stp_spi_slave_asserts.sv]
// Port checks of the serial control block
`timescale 1ns/1ps
`default_nettype none
module stp_spi_slave_asserts
  import stp_pkg::*;
#(
  parameter logic [15:0] WDOG_PULSE_CYCLES = 16'h0010
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic spi_clk,
  input wire logic chip_sel_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic hard_reset_in,
  input wire stp_status_t status_evt,
  input wire stp_ctrl_out_t ctrl_out,
  input wire logic fault_out_n,
  input wire logic por_wdog_out_n,
  input wire logic drivers_hiz,
  input wire logic osc_run
);
  logic [15:0] low_cnt;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) low_cnt <= '0;
    else if (!por_wdog_out_n) low_cnt <= low_cnt + 16'h0001;
    else low_cnt <= '0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence sel_held; !chip_sel_n [*4]; endsequence
  sequence hr_held; hard_reset_in [*4] ##0 !drivers_hiz; endsequence
  sequence flt_seen; chip_sel_n && !hard_reset_in && (|status_evt[3:1] || |status_evt[0][5:0]); endsequence
  oe_sel_a: assert property (serial_out_oe == !chip_sel_n) else $error("oe vs select");
  ctrl_hold_a: assert property (sel_held |=> $stable(ctrl_out)) else $error("ctrl moved in frame");
  fault_hold_a: assert property (sel_held |=> $stable(fault_out_n)) else $error("fault moved");
  hr_clear_a: assert property (hr_held |-> ctrl_out == '0) else $error("ctrl not cleared");
  hr_por_a: assert property (hr_held |-> por_wdog_out_n) else $error("reset out in hard reset");
  fault_set_a: assert property (flt_seen ##1 (chip_sel_n && !hard_reset_in) [*4] |=> !fault_out_n)
    else $error("fault not raised");
  osc_gate_a: assert property ((chip_sel_n && drivers_hiz) [*3] |-> !osc_run) else $error("osc runs");
  osc_run_a: assert property (!drivers_hiz |-> osc_run) else $error("osc stopped awake");
  por_len_a: assert property ($rose(por_wdog_out_n) |-> low_cnt == WDOG_PULSE_CYCLES)
    else $error("pulse length");
endmodule
`default_nettype wire

// [test/stp_master.sv]
// Serial bus master model
`timescale 1ns/1ps
`default_nettype none
module stp_master (
  output logic spi_clk,
  output logic chip_sel_n,
  output logic serial_in,
  input wire logic line_in,
  output logic [15:0] rx_word,
  output logic rx_stb
);
  initial begin
    spi_clk = 1'b0;
    chip_sel_n = 1'b1;
    serial_in = 1'b0;
    rx_word = '0;
    rx_stb = 1'b0;
  end
  // Mode 0, MSB first, idle-low clock; gap stalls between bytes
  task automatic frame(input logic [23:0] tx, input int n, input int gap);
    #7 chip_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = tx[i];
      #15 spi_clk = 1'b1;
      rx_word = {rx_word[14:0], line_in};
      #15 spi_clk = 1'b0;
      if (i % 8 == 0) #(gap);
    end
    #15 chip_sel_n = 1'b1; // Deselect right after the frame
    serial_in = ~serial_in;
    rx_stb = 1'b1;
    #1 rx_stb = 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/test_stp_spi_slave.sv]
// Bench of the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "stp_regs.svh"
module test_stp_spi_slave
  import stp_pkg::*;
;
  localparam int UNIT = 50;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hard_reset_in = 1'b0;
  stp_status_t status_evt = '0;
  logic spi_clk, chip_sel_n, serial_in, serial_out, serial_out_oe;
  logic fault_out_n, por_wdog_out_n, drivers_hiz, osc_run, rx_stb;
  logic [15:0] rx_word;
  stp_ctrl_out_t ctrl_out;
  int fail_count = 0;
  int n_compared = 0;
  logic [7:0] regs [4] = '{default: 8'h00};
  typedef struct {logic [15:0] v; logic [15:0] m;} stp_exp_t;
  stp_exp_t exp_q [$];
  wire logic line = serial_out_oe ? serial_out : 1'b1; // Pull-up while released
  always #20 mclk = ~mclk;
  stp_spi_slave #(.WDOG_UNIT_CYCLES(UNIT)) dut (.mclk(mclk), .reset(reset), .spi_clk(spi_clk),
    .chip_sel_n(chip_sel_n), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .hard_reset_in(hard_reset_in), .status_evt(status_evt), .ctrl_out(ctrl_out), .fault_out_n(fault_out_n),
    .por_wdog_out_n(por_wdog_out_n), .drivers_hiz(drivers_hiz), .osc_run(osc_run));
  stp_master m (.spi_clk(spi_clk), .chip_sel_n(chip_sel_n), .serial_in(serial_in), .line_in(line),
    .rx_word(rx_word), .rx_stb(rx_stb));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge rx_stb) begin
    stp_exp_t e;
    e = exp_q.pop_front();
    check(rx_word & e.m, e.v & e.m, "serial data");
  end
  task automatic xfer(input logic [23:0] tx, input int n, input logic [15:0] v, input logic [15:0] mk);
    exp_q.push_back('{v, mk});
    m.frame(tx, n, $urandom_range(0, 1) * 45);
    repeat (6) @(posedge mclk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] v);
    xfer({11'h000, a, 8'h00}, 16, {8'h00, v}, 16'h00ff);
  endtask
  function automatic logic [7:0] wm(input int a);
    case (a)
      0: return `STP_WMASK_WDOG;
      1: return `STP_WMASK_STEP;
      2: return `STP_WMASK_DRIVE;
      default: return `STP_WMASK_POWER;
    endcase
  endfunction
  task automatic wreg(input int a, input logic [7:0] d);
    // Addresses above the control block return the idle status value and take no write
    xfer({8'h00, 3'h4, 5'(a), d}, 16, {8'h00, (a < 4) ? regs[a & 3] : 8'h00}, 16'h00ff);
    if (a < 4) regs[a & 3] = d & wm(a);
  endtask
  task automatic hr_pulse();
    @(posedge mclk) hard_reset_in <= 1'b1;
    repeat (6) @(posedge mclk);
    check({15'h0000, por_wdog_out_n}, 16'h0001, "reset out");
    hard_reset_in <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wait_fire(output int t);
    t = 0;
    while (por_wdog_out_n === 1'b1 && t < 400) begin
      @(posedge mclk);
      t++;
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    $display("watchdog expired");
    summarize();
  end
  initial begin
    logic [7:0] d;
    logic [6:0] s;
    int t;
    int bad [3] = '{15, 17, 24};
    void'($urandom(32'h254aec98));
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 4; a++) rd(5'(a), 8'h00);
    rd(5'h1f, 8'h00);
    for (int a = 0; a < 4; a++) begin
      d = $urandom();
      if (a == 0) d[7] = 1'b0;
      if (a == 3) d[6] = 1'b0;
      wreg(a, d);
      rd(5'(a), regs[a]);
    end
    check({8'h00, ctrl_out.step_mode_sel, ctrl_out.peak_current_sel}, {8'h00, regs[1]}, "step fields");
    d = $urandom();
    xfer({3'h0, 5'h01, 3'h4, 5'h02, d}, 24, {regs[1], regs[2]}, 16'hffff);
    regs[2] = d & wm(2);
    foreach (bad[i]) xfer(24'h81a53c >> (24 - bad[i]), bad[i], 16'h0000, 16'h0000);
    rd(5'h01, regs[1]);
    $display("done: register access");
    wreg(4, 8'h7f);
    rd(5'h04, 8'h00);
    for (int a = 1; a < 4; a++) begin
      s = 7'($urandom_range(1, 127));
      @(posedge mclk) status_evt[a] <= s;
      @(posedge mclk) status_evt[a] <= 7'h00;
      repeat (4) @(posedge mclk);
      check({15'h0000, fault_out_n}, 16'h0000, "fault");
      rd(5'(a + 4), {^s, s});
      rd(5'(a + 4), 8'h00);
      check({15'h0000, fault_out_n}, 16'h0001, "fault");
    end
    $display("done: status");
    wreg(3, 8'h40);
    check({14'h0000, drivers_hiz, osc_run}, 16'h0002, "sleep outs");
    hr_pulse();
    rd(5'h01, regs[1]);
    wreg(3, 8'h00);
    check({14'h0000, drivers_hiz, osc_run}, 16'h0001, "awake outs");
    hr_pulse();
    regs = '{default: 8'h00};
    rd(5'h01, 8'h00);
    $display("done: sleep and hard reset");
    wreg(0, 8'h88);
    repeat (60) @(posedge mclk);
    wreg(0, 8'h88);
    wait_fire(t);
    check({15'h0000, t >= 2 * UNIT - 6 && t <= 2 * UNIT + 2}, 16'h0001, "timeout");
    repeat (20) @(posedge mclk);
    rd(5'h04, 8'hc0);
    hr_pulse();
    repeat (300) @(posedge mclk);
    check({15'h0000, por_wdog_out_n}, 16'h0001, "disarmed");
    regs = '{default: 8'h00};
    wreg(0, 8'h80);
    wreg(3, 8'h40);
    repeat (200) @(posedge mclk);
    check({15'h0000, por_wdog_out_n}, 16'h0001, "frozen");
    wreg(3, 8'h00);
    wait_fire(t);
    check({15'h0000, t >= 5 && t <= 35}, 16'h0001, "resumed");
    repeat (20) @(posedge mclk);
    hr_pulse();
    $display("done: watchdog");
    check(16'(exp_q.size()), 16'h0000, "pending reads");
    summarize();
  end
endmodule
bind stp_spi_slave stp_spi_slave_asserts #(.WDOG_PULSE_CYCLES(WDOG_PULSE_CYCLES)) chk (.mclk(mclk),
  .reset(reset), .spi_clk(spi_clk), .chip_sel_n(chip_sel_n), .serial_in(serial_in), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .hard_reset_in(hard_reset_in), .status_evt(status_evt), .ctrl_out(ctrl_out),
  .fault_out_n(fault_out_n), .por_wdog_out_n(por_wdog_out_n), .drivers_hiz(drivers_hiz), .osc_run(osc_run));
`default_nettype wire
